// ==== logic/sfc_pkg.sv ====
// constants, commands and carriers shared by the serial flash command front end
// assumes a single 200 MHz core clock; link pins are sampled, not clocked on
package sfc_pkg;

    // clock rate in MHz
    localparam int CLK_MHZ        = 200;

    // array geometry
    localparam int ADDR_W         = 22;
    localparam int ARRAY_BYTES    = 4194304;
    localparam int SECTOR_COUNT   = 64;
    localparam int SECTOR_BITS    = 16;
    localparam int PAGE_BITS      = 8;
    localparam int PAGE_BYTES     = 256;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // instruction codes
    localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_IDENT_READ    = 8'h9F;
    localparam logic [7:0] OPC_STATUS_READ   = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] OPC_READ_DATA     = 8'h03;
    localparam logic [7:0] OPC_FAST_READ     = 8'h0B;
    localparam logic [7:0] OPC_PAGE_PROGRAM  = 8'h02;
    localparam logic [7:0] OPC_SECTOR_ERASE  = 8'hD8;
    localparam logic [7:0] OPC_BULK_ERASE    = 8'hC7;
    localparam logic [7:0] OPC_DEEP_POWER    = 8'hB9;
    localparam logic [7:0] OPC_RELEASE_SIG   = 8'hAB;

    // bytes received before the first output byte (opcode included)
    localparam logic [9:0] HDR_SHORT      = 10'h001;
    localparam logic [9:0] HDR_ADDR       = 10'h004;
    localparam logic [9:0] HDR_FAST       = 10'h005;
    localparam logic [9:0] HDR_SIG        = 10'h004;

    // status layout
    localparam int ST_WIP         = 0;
    localparam int ST_WEL         = 1;
    localparam logic [7:0] ST_KEEP_MASK = 8'h9C;
    localparam logic [7:0] ST_RESET     = 8'h00;
    localparam logic [7:0] ST_BP_MASK   = 8'h1C;

    // self-timed status write length
    localparam int STATUS_CYCLES  = 16;

    // idle level of the sampled pins {cs_n, sclk, si, pause_n}
    localparam logic [3:0] PINS_IDLE = 4'h9;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
        logic pause_n;
    } sfc_pins_t;

    typedef enum logic [3:0] {
        no_cmd,
        write_enable_cmd,
        write_disable_cmd,
        identification_read_cmd,
        status_read_cmd,
        status_write_cmd,
        read_data_cmd,
        fast_read_cmd,
        page_program_cmd,
        sector_erase_cmd,
        bulk_erase_cmd,
        deep_power_down_cmd,
        power_release_signature_cmd
    } sfc_cmd_t;

    typedef enum logic [1:0] {
        eng_idle,
        eng_program,
        eng_erase,
        eng_status
    } sfc_eng_t;

endpackage : sfc_pkg

// ==== logic/sfc_sync.sv ====
// two-stage synchroniser for a group of asynchronous pins
// assumes inputs are quasi-static relative to clk_in over two cycles
`timescale 1ns/1ps
module sfc_sync #(
    parameter int         W     = 4,
    parameter logic [W-1:0] RST_P = '0
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    // pins
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    // first stage is read only by the second
    always_comb begin
        meta_nxt = d_in;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_r <= RST_P;
            q_out  <= RST_P;
        end else begin
            meta_r <= meta_nxt;
            q_out  <= q_nxt;
        end
    end

endmodule : sfc_sync

// ==== logic/sfc_pause.sv ====
// pause tracker: follows the pause pin, changing state only while sclk is low
// assumes synchronised pins; deselect always clears the pause
`timescale 1ns/1ps
module sfc_pause (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic nrst_in,
    // synchronised pins
    input  wire logic cs_n_in,
    input  wire logic sclk_in,
    input  wire logic pause_n_in,
    // state
    output logic      paused_out
);

    logic paused_nxt;

    // a pause edge with sclk high waits for sclk to fall
    always_comb begin
        paused_nxt = paused_out;
        if (cs_n_in) begin
            paused_nxt = 1'b0;
        end else if (!sclk_in) begin
            paused_nxt = !pause_n_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            paused_out <= 1'b0;
        end else begin
            paused_out <= paused_nxt;
        end
    end

endmodule : sfc_pause

// ==== logic/sfc_front_end.sv ====
// serial flash command front end: spi slave, decoder, array and write engine
// assumes the master drives mode 0/3 with sclk well below clk_in / 8
`timescale 1ns/1ps
module sfc_front_end import sfc_pkg::*; #(
    parameter int          STATUS_CYCLES_P = STATUS_CYCLES,
    parameter logic [7:0]  SIGNATURE_P     = 8'h5A,      // arbitrary value
    parameter logic [23:0] IDENT_P         = 24'hA5_C3E1 // arbitrary value
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic nrst_in,
    // spi link pins
    input  wire logic cs_n_in,
    input  wire logic sclk_in,
    input  wire logic si_in,
    input  wire logic pause_n_in,
    output logic      so_out,
    output logic      so_oe_out,
    // device state
    output logic      write_in_progress_out,
    output logic      deep_power_down_out
);

    // sampled pins and edges
    sfc_pins_t pins_raw;
    sfc_pins_t pins;
    logic      paused;
    logic      sclk_d_r;
    logic      cs_d_r;
    logic      selected;
    logic      sclk_rise;
    logic      sclk_fall;
    logic      cs_rise;

    // interface state
    sfc_cmd_t          cmd_r,      cmd_nxt;
    logic [2:0]        bit_r,      bit_nxt;
    logic [9:0]        bytes_r,    bytes_nxt;
    logic [7:0]        rx_r,       rx_nxt;
    logic [ADDR_W-1:0] addr_r,     addr_nxt;
    logic [7:0]        obyte_r,    obyte_nxt;
    logic              so_nxt;
    logic              oen_r,      oen_nxt;
    logic [7:0]        status_write_cmd_r,     status_write_cmd_nxt;
    logic [PAGE_BYTES-1:0] pbv_r,  pbv_nxt;
    logic [7:0]        rx_byte;
    logic [7:0]        cur_out;
    logic              pb_we;

    // core state
    sfc_eng_t          eng_r,      eng_nxt;
    logic [ADDR_W-1:0] walk_r,     walk_nxt;
    logic [ADDR_W-1:0] wend_r,     wend_nxt;
    logic [15:0]       wait_r,     wait_nxt;
    logic [7:0]        srnv_r,     srnv_nxt;
    logic              wel_r,      wel_nxt;
    logic              dpd_r,      dpd_nxt;
    logic              busy;
    logic              mem_we;
    logic [7:0]        mem_wd;
    logic [7:0]        status_byte;

    // storage
    logic [7:0] mem_q   [0:ARRAY_BYTES-1];
    logic [7:0] pbuf_q  [0:PAGE_BYTES-1];

    // opcode to command, gated by busy and power-down
    function automatic sfc_cmd_t decode(input logic [7:0] op, input logic bsy,
                                        input logic dpd);
        sfc_cmd_t c;
        c = no_cmd;
        case (op)
            OPC_WRITE_ENABLE:  c = write_enable_cmd;
            OPC_WRITE_DISABLE: c = write_disable_cmd;
            OPC_IDENT_READ:    c = identification_read_cmd;
            OPC_STATUS_READ:   c = status_read_cmd;
            OPC_STATUS_WRITE:  c = status_write_cmd;
            OPC_READ_DATA:     c = read_data_cmd;
            OPC_FAST_READ:     c = fast_read_cmd;
            OPC_PAGE_PROGRAM:  c = page_program_cmd;
            OPC_SECTOR_ERASE:  c = sector_erase_cmd;
            OPC_BULK_ERASE:    c = bulk_erase_cmd;
            OPC_DEEP_POWER:    c = deep_power_down_cmd;
            OPC_RELEASE_SIG:   c = power_release_signature_cmd;
            default:           c = no_cmd;
        endcase
        if (dpd && c != power_release_signature_cmd) begin
            c = no_cmd;
        end
        if (bsy && c != status_read_cmd) begin
            c = no_cmd;
        end
        return c;
    endfunction : decode

    // bytes before output starts; zero marks a non-read command
    function automatic logic [9:0] hdr_len(input sfc_cmd_t c);
        logic [9:0] n;
        n = 10'h000;
        case (c)
            status_read_cmd:             n = HDR_SHORT;
            identification_read_cmd:     n = HDR_SHORT;
            read_data_cmd:               n = HDR_ADDR;
            fast_read_cmd:               n = HDR_FAST;
            power_release_signature_cmd: n = HDR_SIG;
            default:                     n = 10'h000;
        endcase
        return n;
    endfunction : hdr_len

    // pin sampling
    assign pins_raw = '{cs_n: cs_n_in, sclk: sclk_in, si: si_in, pause_n: pause_n_in};

    sfc_sync #(
        .W     (4),
        .RST_P (PINS_IDLE)
    ) u_sync (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .d_in    (pins_raw),
        .q_out   (pins)
    );

    sfc_pause u_pause (
        .clk_in     (clk_in),
        .nrst_in    (nrst_in),
        .cs_n_in    (pins.cs_n),
        .sclk_in    (pins.sclk),
        .pause_n_in (pins.pause_n),
        .paused_out (paused)
    );

    // edges are masked while paused so the bit count is frozen
    assign selected  = !pins.cs_n;
    assign sclk_rise = selected && !paused && pins.sclk && !sclk_d_r;
    assign sclk_fall = selected && !paused && !pins.sclk && sclk_d_r;
    assign cs_rise   = pins.cs_n && !cs_d_r;
    assign rx_byte   = {rx_r[6:0], pins.si};
    assign busy      = (eng_r != eng_idle);
    assign status_byte = {srnv_r[7], 2'b00, srnv_r[4:2], wel_r, busy};

    // byte offered at the next output boundary
    always_comb begin
        cur_out = 8'h00;
        case (cmd_r)
            status_read_cmd:             cur_out = status_byte;
            power_release_signature_cmd: cur_out = SIGNATURE_P;
            read_data_cmd,
            fast_read_cmd:               cur_out = mem_q[addr_r];
            identification_read_cmd: begin
                if (bytes_r == 10'h001) begin
                    cur_out = IDENT_P[23:16];
                end else if (bytes_r == 10'h002) begin
                    cur_out = IDENT_P[15:8];
                end else if (bytes_r == 10'h003) begin
                    cur_out = IDENT_P[7:0];
                end
            end
            default:                     cur_out = 8'h00;
        endcase
    end

    // serial interface: shift in on rise, shift out on fall
    always_comb begin
        cmd_nxt   = cmd_r;
        bit_nxt   = bit_r;
        bytes_nxt = bytes_r;
        rx_nxt    = rx_r;
        addr_nxt  = addr_r;
        obyte_nxt = obyte_r;
        so_nxt    = so_out;
        oen_nxt   = oen_r;
        status_write_cmd_nxt  = status_write_cmd_r;
        pbv_nxt   = pbv_r;
        pb_we     = 1'b0;
        if (!selected) begin
            // deselect clears command, bit and byte counts and output enable, paused or not
            cmd_nxt   = no_cmd;
            bit_nxt   = 3'd0;
            bytes_nxt = 10'h000;
            oen_nxt   = 1'b0;
        end else begin
            if (sclk_rise) begin
                rx_nxt  = rx_byte;
                bit_nxt = bit_r + 3'd1;
                if (bit_r == 3'd7) begin
                    if (bytes_r != 10'h3FF) begin
                        bytes_nxt = bytes_r + 10'h001;
                    end
                    if (bytes_r == 10'h000) begin
                        cmd_nxt = decode(rx_byte, busy, dpd_r);
                        if (rx_byte == OPC_PAGE_PROGRAM && !busy && !dpd_r) begin
                            pbv_nxt = '0;
                        end
                    end else if (bytes_r < HDR_ADDR && (cmd_r == read_data_cmd ||
                             cmd_r == fast_read_cmd || cmd_r == page_program_cmd ||
                             cmd_r == sector_erase_cmd)) begin
                        addr_nxt = {addr_r[ADDR_W-9:0], rx_byte};
                    end else if (cmd_r == page_program_cmd) begin
                        // data wraps inside the addressed page
                        pb_we = 1'b1;
                        pbv_nxt[addr_r[PAGE_BITS-1:0]] = 1'b1;
                        addr_nxt[PAGE_BITS-1:0] = addr_r[PAGE_BITS-1:0] + 8'h01;
                    end else if (cmd_r == status_write_cmd && bytes_r == 10'h001) begin
                        status_write_cmd_nxt = rx_byte;
                    end
                end
            end
            if (sclk_fall) begin
                if (bit_r == 3'd0 && hdr_len(cmd_r) != 10'h000 &&
                    bytes_r >= hdr_len(cmd_r)) begin
                    obyte_nxt = cur_out;
                    so_nxt    = cur_out[7];
                    oen_nxt   = 1'b1;
                    if (cmd_r == read_data_cmd || cmd_r == fast_read_cmd) begin
                        addr_nxt = addr_r + 22'h00_0001;
                    end
                end else begin
                    so_nxt = obyte_r[3'd7 - bit_r];
                end
            end
        end
    end

    // output enable drops at once when paused or deselected
    assign so_oe_out = oen_r && selected && !paused;

    // core: execution at deselect and the self-timed engine
    always_comb begin
        eng_nxt  = eng_r;
        walk_nxt = walk_r;
        wend_nxt = wend_r;
        wait_nxt = wait_r;
        srnv_nxt = srnv_r;
        wel_nxt  = wel_r;
        dpd_nxt  = dpd_r;
        mem_we   = 1'b0;
        mem_wd   = ERASED_BYTE;
        // release takes effect as soon as its opcode is in
        if (sclk_rise && bit_r == 3'd7 && bytes_r == 10'h000 &&
            rx_byte == OPC_RELEASE_SIG && !busy) begin
            dpd_nxt = 1'b0;
        end
        // deselect mid-pause resets the interface; nothing executes
        if (cs_rise && !paused && bit_r == 3'd0) begin
            case (cmd_r)
                write_enable_cmd:    wel_nxt = 1'b1;
                write_disable_cmd:   wel_nxt = 1'b0;
                deep_power_down_cmd: dpd_nxt = 1'b1;
                page_program_cmd: begin
                    if (wel_r && bytes_r > HDR_ADDR) begin
                        eng_nxt  = eng_program;
                        walk_nxt = {addr_r[ADDR_W-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
                        wend_nxt = {addr_r[ADDR_W-1:PAGE_BITS], {PAGE_BITS{1'b1}}};
                    end
                end
                sector_erase_cmd: begin
                    if (wel_r && bytes_r >= HDR_ADDR) begin
                        eng_nxt  = eng_erase;
                        walk_nxt = {addr_r[ADDR_W-1:SECTOR_BITS], {SECTOR_BITS{1'b0}}};
                        wend_nxt = {addr_r[ADDR_W-1:SECTOR_BITS], {SECTOR_BITS{1'b1}}};
                    end
                end
                bulk_erase_cmd: begin
                    if (wel_r && (srnv_r & ST_BP_MASK) == 8'h00) begin
                        eng_nxt  = eng_erase;
                        walk_nxt = '0;
                        wend_nxt = '1;
                    end
                end
                status_write_cmd: begin
                    if (wel_r && bytes_r > HDR_SHORT) begin
                        eng_nxt  = eng_status;
                        wait_nxt = 16'h0000;
                    end
                end
                default: ;
            endcase
        end
        // the engine ignores the pause pin entirely
        unique case (eng_r)
            eng_idle: ;
            eng_program: begin
                // only set bits of the stored byte can be cleared
                mem_we   = pbv_r[walk_r[PAGE_BITS-1:0]];
                mem_wd   = mem_q[walk_r] & pbuf_q[walk_r[PAGE_BITS-1:0]];
                walk_nxt = walk_r + 22'h00_0001;
                if (walk_r == wend_r) begin
                    eng_nxt = eng_idle;
                    wel_nxt = 1'b0;
                end
            end
            eng_erase: begin
                mem_we   = 1'b1;
                mem_wd   = ERASED_BYTE;
                walk_nxt = walk_r + 22'h00_0001;
                if (walk_r == wend_r) begin
                    eng_nxt = eng_idle;
                    wel_nxt = 1'b0;
                end
            end
            eng_status: begin
                wait_nxt = wait_r + 16'h0001;
                if (wait_r == 16'(STATUS_CYCLES_P - 1)) begin
                    srnv_nxt = status_write_cmd_r & ST_KEEP_MASK;
                    eng_nxt  = eng_idle;
                    wel_nxt  = 1'b0;
                end
            end
        endcase
    end

    assign write_in_progress_out = busy;
    assign deep_power_down_out   = dpd_r;

    // array and page buffer, no reset on storage
    always_ff @(posedge clk_in) begin
        if (pb_we) begin
            pbuf_q[addr_r[PAGE_BITS-1:0]] <= rx_byte;
        end
        if (mem_we) begin
            mem_q[walk_r] <= mem_wd;
        end
    end

    // state registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b1;
            cmd_r    <= no_cmd;
            bit_r    <= 3'd0;
            bytes_r  <= 10'h000;
            rx_r     <= 8'h00;
            addr_r   <= '0;
            obyte_r  <= 8'h00;
            so_out   <= 1'b0;
            oen_r    <= 1'b0;
            status_write_cmd_r   <= 8'h00;
            pbv_r    <= '0;
            eng_r    <= eng_idle;
            walk_r   <= '0;
            wend_r   <= '0;
            wait_r   <= 16'h0000;
            srnv_r   <= ST_RESET;
            wel_r    <= 1'b0;
            dpd_r    <= 1'b0;
        end else begin
            sclk_d_r <= pins.sclk;
            cs_d_r   <= pins.cs_n;
            cmd_r    <= cmd_nxt;
            bit_r    <= bit_nxt;
            bytes_r  <= bytes_nxt;
            rx_r     <= rx_nxt;
            addr_r   <= addr_nxt;
            obyte_r  <= obyte_nxt;
            so_out   <= so_nxt;
            oen_r    <= oen_nxt;
            status_write_cmd_r   <= status_write_cmd_nxt;
            pbv_r    <= pbv_nxt;
            eng_r    <= eng_nxt;
            walk_r   <= walk_nxt;
            wend_r   <= wend_nxt;
            wait_r   <= wait_nxt;
            srnv_r   <= srnv_nxt;
            wel_r    <= wel_nxt;
            dpd_r    <= dpd_nxt;
        end
    end

endmodule : sfc_front_end

// ==== bench/sfc_master.sv ====
// spi master model for the flash front end: mode 0, msb first
// assumes a 48 ns serial clock and that so floats while so_oe is low
`timescale 1ns/1ps
module sfc_master (
    // link pins toward the device
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      si_out,
    output logic      pause_n_out,
    // device answer
    input  wire logic so_in,
    input  wire logic so_oe_in
);
    logic last_r; // a floating line shows the inverse of the last bit
    // idle levels from time zero
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        si_out = 1'b0;
        pause_n_out = 1'b1;
        last_r = 1'b0;
    end
    // pause is always raised before select, so no stale pause returns
    task automatic sel();
        pause_n_out = 1'b1;
        #30 cs_n_out = 1'b0;
        #30;
    endtask : sel
    // deselect at whatever bit count the caller reached
    task automatic desel();
        #30 cs_n_out = 1'b1;
        #60;
    endtask : desel
    // pause only between sel and desel, with sclk low
    task automatic hold(input logic v);
        #24 pause_n_out = v;
        #30;
    endtask : hold
    // one clock pulse; so is taken at the rising edge
    task automatic pulse(input logic b, output logic r);
        si_out = b;
        #24 sclk_out = 1'b1;
        r = so_oe_in ? so_in : ~last_r;
        last_r = r;
        #24 sclk_out = 1'b0;
    endtask : pulse
    // whole bytes, most significant bit first
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) pulse(tx[i], rx[i]);
    endtask : xbyte
endmodule : sfc_master

// ==== bench/sfc_front_end_props.sv ====
// port checker for the flash front end, bound into the front end module
// assumes link pins sampled by clk_in through two-flop synchronisers
`timescale 1ns/1ps
module sfc_props #(
    parameter int STATUS_CYCLES_P = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // link pins
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic si_in,
    input wire logic pause_n_in,
    input wire logic so_out,
    input wire logic so_oe_out,
    // device state
    input wire logic write_in_progress_out,
    input wire logic deep_power_down_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    // held windows cover the synchroniser latency
    sequence s_idle;
        cs_n_in [*4];
    endsequence
    sequence s_held;
        (!cs_n_in && !sclk_in && !pause_n_in) [*5];
    endsequence
    sequence s_new_bit;
        so_oe_out && $past(so_oe_out) && $changed(so_out);
    endsequence
    sequence s_wip_up;
        $rose(write_in_progress_out);
    endsequence
    a_oe_idle: assert property (s_idle |-> !so_oe_out)
        else $error("output enabled while deselected");
    a_pause_float: assert property (s_held |-> !so_oe_out)
        else $error("output driven while paused");
    a_so_on_fall: assert property (s_new_bit |-> !sclk_in)
        else $error("output bit moved while sclk high");
    a_wip_at_desel: assert property (s_wip_up |-> $past(cs_n_in, 2))
        else $error("cycle started while selected");
    a_wip_min_len: assert property (s_wip_up |-> write_in_progress_out [*8])
        else $error("progress flag too short");
    a_dpd_no_wip: assert property (deep_power_down_out |-> !write_in_progress_out)
        else $error("cycle running in power-down");
    a_dpd_at_desel: assert property ($rose(deep_power_down_out) |-> $past(cs_n_in, 2))
        else $error("power-down entered while selected");
    a_release_sel: assert property ($fell(deep_power_down_out) |-> !cs_n_in)
        else $error("release outside a select");
endmodule : sfc_props

bind sfc_front_end sfc_props #(.STATUS_CYCLES_P(STATUS_CYCLES_P)) u_props (
    .clk_in(clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
    .si_in(si_in), .pause_n_in(pause_n_in), .so_out(so_out), .so_oe_out(so_oe_out),
    .write_in_progress_out(write_in_progress_out),
    .deep_power_down_out(deep_power_down_out)
);

// ==== bench/tb_top.sv ====
// self-checking bench: master model drives the link, tasks judge answers
// assumes the flash front end and its bound checker are compiled first
`timescale 1ns/1ps
module tb_top import sfc_pkg::*; ();
    localparam logic [7:0] SIG = 8'h3C; // arbitrary value
    localparam logic [23:0] IDN = 24'h1E_2D4B; // arbitrary value
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic cs_n, sclk, si, pause_n, so, so_oe, write_in_progress, dpd, b;
    logic [7:0] r, s, t;
    int failures = 0;
    int n_compared = 0;
    always #2.5 clk_in = ~clk_in;
    sfc_master m (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .pause_n_out(pause_n),
        .so_in(so), .so_oe_in(so_oe));
    // long self-timed status write so the progress flag can be polled
    sfc_front_end #(.STATUS_CYCLES_P(400), .SIGNATURE_P(SIG), .IDENT_P(IDN)) dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si),
        .pause_n_in(pause_n), .so_out(so), .so_oe_out(so_oe),
        .write_in_progress_out(write_in_progress), .deep_power_down_out(dpd));
    task automatic close_out();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask : chk
    task automatic cmd(input logic [7:0] op);
        m.sel();
        m.xbyte(op, r);
        m.desel();
    endtask : cmd
    task automatic hdr(input logic [7:0] op, input logic [23:0] a);
        m.sel();
        m.xbyte(op, r);
        m.xbyte(a[23:16], r);
        m.xbyte(a[15:8], r);
        m.xbyte(a[7:0], r);
    endtask : hdr
    task automatic rd_st(output logic [7:0] v);
        m.sel();
        m.xbyte(OPC_STATUS_READ, r);
        m.xbyte(8'h00, v);
        m.desel();
    endtask : rd_st
    // bounded wait for the internal cycle to finish
    task automatic wait_idle();
        int i;
        // whole-period steps keep the master on its grid, clear of rising clock edges
        for (i = 0; i < 70000 && write_in_progress !== 1'b0; i++) #5;
        if (i == 70000) begin
            $display("ERROR wip expected 0 seen 1");
            failures++;
            close_out();
        end
    endtask : wait_idle
    // pause mid-byte keeps the bit position; deselect while paused resets
    task automatic t_pause();
        cmd(OPC_WRITE_ENABLE);
        m.sel();
        m.xbyte(OPC_STATUS_READ, r);
        for (int i = 7; i >= 4; i--) m.pulse(1'b0, s[i]);
        m.hold(1'b0);
        chk("so_oe paused", 8'h00, {7'h00, so_oe});
        m.pulse(1'b1, b);
        m.hold(1'b1);
        for (int i = 3; i >= 0; i--) m.pulse(1'b0, s[i]);
        m.xbyte(8'h00, t);
        chk("status paused", 8'h02, s);
        chk("status repeat", 8'h02, t);
        m.pulse(1'b0, b);
        m.hold(1'b0);
        m.desel();
        rd_st(s);
        chk("status after reset", 8'h02, s);
        $display("test pause done");
    endtask : t_pause
    // status write refused off a byte boundary, then run in full
    task automatic t_status();
        m.sel();
        m.xbyte(OPC_STATUS_WRITE, r);
        m.xbyte(8'h80, r);
        repeat (3) m.pulse(1'b0, b);
        m.desel();
        chk("wip misaligned", 8'h00, {7'h00, write_in_progress});
        cmd(OPC_WRITE_ENABLE);
        m.sel();
        m.xbyte(OPC_STATUS_WRITE, r);
        m.xbyte(8'h80, r);
        m.desel();
        rd_st(s);
        chk("wip busy", 8'h01, s & 8'h01);
        cmd(OPC_DEEP_POWER);
        chk("dpd while busy", 8'h00, {7'h00, dpd});
        wait_idle();
        rd_st(s);
        chk("status written", 8'h80, s);
        $display("test status done");
    endtask : t_status
    // power-down, then release with three dummy bytes and signature
    task automatic t_dpd();
        cmd(OPC_DEEP_POWER);
        chk("dpd entered", 8'h01, {7'h00, dpd});
        hdr(OPC_RELEASE_SIG, 24'h00_0000);
        m.xbyte(8'h00, s);
        m.xbyte(8'h00, t);
        m.desel();
        chk("signature", SIG, s);
        chk("signature repeat", SIG, t);
        chk("dpd released", 8'h00, {7'h00, dpd});
        $display("test dpd done");
    endtask : t_dpd
    // erase sector 1, program twice at one byte, fast read across it
    task automatic t_array();
        cmd(OPC_WRITE_ENABLE);
        hdr(OPC_SECTOR_ERASE, 24'h01_0000);
        m.desel();
        wait_idle();
        for (int k = 0; k < 2; k++) begin
            cmd(OPC_WRITE_ENABLE);
            hdr(OPC_PAGE_PROGRAM, 24'h01_00FF);
            m.xbyte(k ? 8'hF3 : 8'h5C, r);
            m.desel();
            wait_idle();
        end
        hdr(OPC_FAST_READ, 24'h01_00FF);
        m.xbyte(8'h00, r);
        m.xbyte(8'h00, s);
        m.xbyte(8'h00, t);
        m.desel();
        chk("programmed byte", 8'h50, s);
        chk("erased neighbour", 8'hFF, t);
        $display("test array done");
    endtask : t_array
    // identification bytes, plain read, write disable clears the latch
    task automatic t_misc();
        m.sel();
        m.xbyte(OPC_IDENT_READ, r);
        for (int i = 2; i >= 0; i--) begin
            m.xbyte(8'h00, s);
            chk("ident byte", IDN[8*i +: 8], s);
        end
        m.desel();
        hdr(OPC_READ_DATA, 24'h01_00FF);
        m.xbyte(8'h00, s);
        m.desel();
        chk("plain read", 8'h50, s);
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_WRITE_DISABLE);
        rd_st(s);
        chk("latch cleared", 8'h00, s & 8'h02);
        $display("test misc done");
    endtask : t_misc
    initial begin
        repeat (4) @(posedge clk_in);
        // master steps are whole nanoseconds, rising clock edges fall on half nanoseconds
        #1.5 nrst_in = 1'b1;
        #20;
        t_pause();
        t_status();
        t_dpd();
        t_array();
        t_misc();
        close_out();
    end
endmodule : tb_top
